//--- bench/motor_pwm_time_base_control_tb.sv
// testbench for the pwm time base control core
// assumes the apb slave adds one wait state and the fuse is tied high
module motor_pwm_time_base_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mptb_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m;} mptb_exp_t;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fuse = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, down, center, tb_ev, trig_ev, irq;
    logic [11:0] count, snap;
    logic [63:0] duty;
    logic [7:0] ovr;
    logic [2:0] pin_en;
    logic [3:0] pair;
    logic [15:0] d;
    int gap, seed = 38, n_errors = 0, n_checks = 0;
    int cyc = 0, t0;
    mptb_exp_t exp_q[$];
    mptb_exp_t e;
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    mptb_core dut (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .pin_reset_config_fuse_in(fuse),
        .timebase_count_out(count), .count_down_flag_out(down), .center_aligned_out(center),
        .tb_event_out(tb_ev), .trigger_event_out(trig_ev), .duty_active_out(duty),
        .override_active_out(ovr), .output_pin_enable_out(pin_en), .pair_mode_out(pair), .irq_out(irq));
    mptb_stage stage (.clk_sys_in(clk), .rst_n_in(rst_n), .tb_event_in(tb_ev), .gap_out(gap));
    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] s);
        n_checks++;
        if (s !== ex) begin
            $display("unexpected %s expected %h seen %h", nm, ex, s);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
        exp_q.push_back('{ex, m});
        apb(1'b0, a, ZERO32);
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? tb_ev : (w == 1) ? irq : (w == 2) ? down : trig_ev;
    endfunction
    task automatic wait_hi(input int w);
        int k;
        k = 0;
        @(posedge clk);
        while (pick(w) !== 1'b1 && k < 5000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 5000) begin
            n_errors++;
            stop_test();
        end
    endtask
    // read data is taken at the edge that samples pready high
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            check("pslverr", 32'h0, {31'h0, pslverr});
            if (!pwrite && exp_q.size() == 0) begin
                $display("unexpected prdata expected none seen %h", prdata);
                n_errors++;
            end else if (!pwrite) begin
                e = exp_q.pop_front();
                check("prdata", e.d & e.m, prdata & e.m);
            end
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ADDR_TCTL0, 32'h0, 32'hFFFF_FFFF);
        rd(ADDR_OCTL0, 32'h70, 32'hFFFF_FFFF);
        check("pin_en", 32'h7, {29'h0, pin_en});
        rd(ADDR_OCTL1, 32'h0, 32'hFFFF_FFFF);
        rd(8'hFC, 32'h0, 32'hFFFF_FFFF);
        wr(ADDR_TCTL1, 32'h7F);
        rd(ADDR_TCTL1, 32'h0, 32'hFFFF_FFFF);
        wr(ADDR_OCTL0, 32'hFF);
        rd(ADDR_OCTL0, 32'h7F, 32'hFFFF_FFFF);
        wr(ADDR_OCTL0, 32'h75);
        check("pair", 32'h5, {28'h0, pair});
        d = $random(seed);
        wr(ADDR_OVR, {24'h0, d[7:0]});
        @(posedge clk);
        check("ovr", {24'h0, d[7:0]}, {24'h0, ovr});
        // prescale table with postscale 1:2 and period 3; gap is measured by the stage
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_TCTL1, 32'h0);
            wr(ADDR_TCTL0, 32'h10 | (p << 2));
            wr(ADDR_PERIOD, 32'h3);
            wr(ADDR_TCTL1, 32'h80);
            repeat (3) wait_hi(0);
            @(posedge clk);
            check("gap", 32'd32 << (2 * p), gap);
        end
        wr(ADDR_TCTL1, 32'h0);
        wr(ADDR_TCTL0, 32'h0);
        wr(ADDR_TCTL1, 32'h80);
        d = $random(seed);
        wr(ADDR_DUTY0, {16'h0, d});
        repeat (2) wait_hi(0);
        repeat (2) @(posedge clk);
        check("duty0", {16'h0, d}, {16'h0, duty[15:0]});
        wr(ADDR_OCTL1, 32'h02);
        wr(ADDR_DUTY0, {16'h0, ~d});
        repeat (2) wait_hi(0);
        repeat (2) @(posedge clk);
        check("duty0", {16'h0, d}, {16'h0, duty[15:0]});
        wr(ADDR_OCTL1, 32'h0);
        // synced override waits for the next period boundary
        wr(ADDR_OVR, {24'h0, d[7:0]});
        wr(ADDR_OCTL1, 32'h01);
        wait_hi(0);
        wr(ADDR_OVR, {24'h0, ~d[7:0]});
        @(posedge clk);
        check("ovr", {24'h0, d[7:0]}, {24'h0, ovr});
        wait_hi(0);
        check("ovr", {24'h0, ~d[7:0]}, {24'h0, ovr});
        // trigger at count 2 every period, postscale 1:2 gives 32 clocks
        wr(ADDR_OCTL1, 32'h10);
        wr(ADDR_TRIG, 32'h2);
        repeat (2) wait_hi(3);
        t0 = cyc;
        wait_hi(3);
        check("trig_gap", 32'd32, cyc - t0);
        // events while masked must not raise the interrupt
        repeat (2) @(posedge clk);
        check("irq", 32'h0, {31'h0, irq});
        wr(ADDR_MASK, 32'h1);
        wait_hi(1);
        wr(ADDR_TCTL1, 32'h0);
        snap = count;
        repeat (20) @(posedge clk);
        check("count", {20'h0, snap}, {20'h0, count});
        rd(ADDR_STAT, 32'h1, 32'h1);
        @(posedge clk);
        check("irq", 32'h0, {31'h0, irq});
        wr(ADDR_TCTL0, 32'h2);
        wr(ADDR_TCTL1, 32'h80);
        wait_hi(2);
        check("center", 32'h1, {31'h0, center});
        repeat (3) wait_hi(0);
        @(posedge clk);
        check("gap", 32'd24, gap);
        wr(ADDR_TCTL1, 32'h0);
        wr(ADDR_TCTL0, 32'h3);
        wr(ADDR_TCTL1, 32'h80);
        repeat (3) wait_hi(0);
        @(posedge clk);
        check("gap", 32'd12, gap);
        wr(ADDR_TCTL1, 32'h0);
        wr(ADDR_TCTL0, 32'h1);
        wr(ADDR_TCTL1, 32'h80);
        wait_hi(0);
        repeat (8) @(posedge clk);
        rd(ADDR_TCTL1, 32'h0, 32'h80);
        check("center", 32'h0, {31'h0, center});
        stop_test();
    end
endmodule

//--- bench/mptb_stage.sv
// far-side model: a power stage that only sees the time base events
// assumes events are one-cycle pulses on clk_sys_in
module mptb_stage (
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    input  wire logic tb_event_in,
    output int        gap_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // gap in clocks between the last two events; the stage needs a steady period
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
            gap_out <= 0;
        end else if (tb_event_in) begin
            gap_out <= cnt + 1;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- src/mptb_core.sv
// time base, prescaler, postscalers and control registers of the pwm unit
// assumes an apb master on clk_sys_in; no other clock domain
//
// How it works
// - 12-bit counter, prescaled input, postscaled match
// - run bit 7 gates counting
// - clearing run keeps count value
// - mode 00 free running, 01 single shot
// - 10 up/down, 11 events at zero and period
// - edge aligned or center aligned output flag
// - bit 6 read-only down direction flag
// - input clock is system clock over four
// - 4-bit match postscaler up to 1:16
// - seven value registers double buffered
// - pin enable reset follows fuse input
// - unimplemented control bits read zero
// - trigger postscaler 1:1 to 1:16
// - update block stops duty transfers
// - override sync to time base selectable
//
// Chosen here: the register addresses and the APB register port.
module mptb_core
    import mptb_pkg::*;
#(
    parameter int CNT_WIDTH = CNT_W
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    input  wire logic                  pin_reset_config_fuse_in,
    output logic      [CNT_WIDTH-1:0]  timebase_count_out,
    output logic                       count_down_flag_out,
    output logic                       center_aligned_out,
    output logic                       tb_event_out,
    output logic                       trigger_event_out,
    output logic [NUM_DUTY*VAL_W-1:0]  duty_active_out,
    output logic      [7:0]            override_active_out,
    output logic      [2:0]            output_pin_enable_out,
    output logic      [3:0]            pair_mode_out,
    output logic                       irq_out
);
    import mptb_pkg::*;

    logic [1:0] fuse_sync_reg;
    logic [2:0] fuse_seen_reg;
    mptb_tctl0_t tctl0_reg;
    logic        run_reg, dir_reg;
    logic [7:0]  octl0_reg, octl1_reg;
    logic [VAL_W-1:0] period_buf_reg, period_act_reg, trig_buf_reg, trig_act_reg;
    logic [VAL_W-1:0] duty_buf_reg [NUM_DUTY];
    logic [NUM_DUTY*VAL_W-1:0] duty_act_reg;
    logic [7:0]  ovr_buf_reg, ovr_act_reg;
    logic [CNT_WIDTH-1:0] cnt_reg;
    logic [1:0]  instr_reg;
    logic [5:0]  pre_reg;
    logic [3:0]  post_reg, tpost_reg;
    logic [1:0]  stat_reg, mask_reg;
    logic [31:0] rdata_reg;
    logic        ready_reg, tbev_reg, trev_reg, irq_reg;

    wire access_w = psel_in & penable_in & ready_reg;
    wire wr_w = access_w & pwrite_in;
    wire rd_w = access_w & ~pwrite_in;
    wire wr_tctl0_w = wr_w && paddr_in == ADDR_TCTL0;
    wire wr_tctl1_w = wr_w && paddr_in == ADDR_TCTL1;
    wire wr_count_w = wr_w && paddr_in == ADDR_COUNT;
    wire rd_stat_w  = rd_w && paddr_in == ADDR_STAT;
    // prescaler and postscalers restart on count or time base control (TCTL0, TCTL1) writes
    wire clr_scalers_w = wr_tctl0_w | wr_tctl1_w | wr_count_w;
    // incoming control word, so a mode change can park the direction flag
    wire mptb_tctl0_t tctl0_wr_w = mptb_tctl0_t'(pwdata_in[7:0]);
    // fuse level valid only once both sync stages hold it
    wire fuse_load_w = fuse_seen_reg[1] & ~fuse_seen_reg[2];

    wire instr_tick_w = instr_reg == INSTR_DIV_LAST;
    // divider code to last prescale count
    wire [5:0] pre_last_w = tctl0_reg.input_divider_sel == 2'b00 ? 6'h00 :
                            tctl0_reg.input_divider_sel == 2'b01 ? 6'h03 :
                            tctl0_reg.input_divider_sel == 2'b10 ? 6'h0F : 6'h3F;
    wire tick_w = run_reg & instr_tick_w & (pre_reg == pre_last_w);
    wire [CNT_WIDTH-1:0] per_w = period_act_reg[CNT_WIDTH-1:0];
    wire updown_w = tctl0_reg.timebase_mode_sel[1];
    wire match_w = cnt_reg == per_w;
    wire zero_w = cnt_reg == '0;
    // raw time base events per mode
    wire raw_ev_w = tick_w & (updown_w ? ((zero_w & dir_reg) |
                    (tctl0_reg.timebase_mode_sel == MPTB_DOUBLE & match_w & ~dir_reg)) : match_w);
    // match postscaler, bypassed in single shot
    wire tb_ev_w = raw_ev_w & ((tctl0_reg.timebase_mode_sel == MPTB_SINGLE) ||
                   post_reg == tctl0_reg.match_postscale_sel);
    wire trig_hit_w = tick_w & (cnt_reg == trig_act_reg[CNT_WIDTH-1:0]) &
                      (dir_reg == octl1_reg[3]);
    wire tr_ev_w = trig_hit_w & (tpost_reg == octl1_reg[7:4]);
    // reload point of buffered values
    wire reload_w = updown_w ? (tick_w & zero_w) : (tick_w & match_w);
    wire duty_load_w = (reload_w | ~run_reg) & ~octl1_reg[1];
    wire ovr_load_w = octl1_reg[0] ? (reload_w | ~run_reg) : 1'b1;

    logic [31:0] rmux_w;
    always_comb begin
        rmux_w = ZERO32;
        case (paddr_in)
            ADDR_TCTL0:  rmux_w = {24'h0, tctl0_reg};
            ADDR_TCTL1:  rmux_w = {24'h0, run_reg, dir_reg, 6'h00};
            ADDR_OCTL0:  rmux_w = {24'h0, octl0_reg & OCTL0_MASK};
            ADDR_OCTL1:  rmux_w = {24'h0, octl1_reg & OCTL1_MASK};
            ADDR_COUNT:  rmux_w = {20'h0, cnt_reg};
            ADDR_PERIOD: rmux_w = {16'h0, period_buf_reg};
            ADDR_TRIG:   rmux_w = {16'h0, trig_buf_reg};
            ADDR_STAT:   rmux_w = {30'h0, stat_reg};
            ADDR_MASK:   rmux_w = {30'h0, mask_reg};
            ADDR_OVR:    rmux_w = {24'h0, ovr_buf_reg};
            default: begin
                for (int i = 0; i < NUM_DUTY; i++) begin
                    if (paddr_in == ADDR_DUTY0 + 8'(4 * i)) begin
                        rmux_w = {16'h0, duty_buf_reg[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_reg <= 1'b0;
            rdata_reg <= ZERO32;
        end else begin
            // one wait state: ready in the second access cycle
            ready_reg <= psel_in & penable_in & ~ready_reg;
            if (psel_in & penable_in & ~ready_reg) begin
                rdata_reg <= rmux_w;
            end
        end
    end

    // fuse sampled after reset release, synchronised first
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fuse_sync_reg <= 2'b00;
            fuse_seen_reg <= 3'b000;
        end else begin
            fuse_sync_reg <= {fuse_sync_reg[0], pin_reset_config_fuse_in};
            fuse_seen_reg <= {fuse_seen_reg[1:0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tctl0_reg <= '0;
            octl0_reg <= RST_ZERO;
            octl1_reg <= RST_ZERO;
            period_buf_reg <= '0;
            trig_buf_reg <= '0;
            ovr_buf_reg <= RST_ZERO;
            mask_reg <= 2'b00;
        end else begin
            if (fuse_load_w) begin
                // pin enable reset value from fuse
                octl0_reg[6:4] <= fuse_sync_reg[1] ? PINEN_FUSE1 : PINEN_FUSE0;
            end else if (wr_w && paddr_in == ADDR_OCTL0) begin
                octl0_reg <= pwdata_in[7:0] & OCTL0_MASK;
            end
            if (wr_tctl0_w) begin
                tctl0_reg <= pwdata_in[7:0];
            end
            if (wr_w && paddr_in == ADDR_OCTL1) begin
                octl1_reg <= pwdata_in[7:0] & OCTL1_MASK;
            end
            if (wr_w && paddr_in == ADDR_PERIOD) begin
                period_buf_reg <= pwdata_in[VAL_W-1:0];
            end
            if (wr_w && paddr_in == ADDR_TRIG) begin
                trig_buf_reg <= pwdata_in[VAL_W-1:0];
            end
            if (wr_w && paddr_in == ADDR_OVR) begin
                ovr_buf_reg <= pwdata_in[7:0];
            end
            if (wr_w && paddr_in == ADDR_MASK) begin
                mask_reg <= pwdata_in[1:0];
            end
        end
    end

    for (genvar g = 0; g < NUM_DUTY; g++) begin : g_duty
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                duty_buf_reg[g] <= '0;
                duty_act_reg[g*VAL_W +: VAL_W] <= '0;
            end else begin
                if (wr_w && paddr_in == ADDR_DUTY0 + 8'(4 * g)) begin
                    duty_buf_reg[g] <= pwdata_in[VAL_W-1:0];
                end
                if (duty_load_w) begin
                    duty_act_reg[g*VAL_W +: VAL_W] <= duty_buf_reg[g];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_reg <= 1'b0;
            dir_reg <= 1'b0;
            cnt_reg <= '0;
            instr_reg <= 2'b00;
            pre_reg <= 6'h00;
            post_reg <= 4'h0;
            tpost_reg <= 4'h0;
            period_act_reg <= '0;
            trig_act_reg <= '0;
            ovr_act_reg <= RST_ZERO;
        end else begin
            instr_reg <= instr_reg + 2'b01;
            if (clr_scalers_w) begin
                pre_reg <= 6'h00;
                post_reg <= 4'h0;
                tpost_reg <= 4'h0;
            end else begin
                if (instr_tick_w) begin
                    pre_reg <= (pre_reg == pre_last_w) ? 6'h00 : pre_reg + 6'h01;
                end
                if (raw_ev_w) begin
                    post_reg <= tb_ev_w ? 4'h0 : post_reg + 4'h1;
                end
                if (trig_hit_w) begin
                    tpost_reg <= tr_ev_w ? 4'h0 : tpost_reg + 4'h1;
                end
            end
            // period and trigger reload at cycle boundary or while stopped
            if (reload_w | ~run_reg) begin
                period_act_reg <= period_buf_reg;
                trig_act_reg <= trig_buf_reg;
            end
            if (ovr_load_w) begin
                ovr_act_reg <= ovr_buf_reg;
            end
            // run bit written, count kept when stopped
            if (wr_tctl1_w) begin
                run_reg <= pwdata_in[RUN_BIT];
            end else if (tick_w && match_w && tctl0_reg.timebase_mode_sel == MPTB_SINGLE) begin
                run_reg <= 1'b0;
            end
            if (wr_count_w) begin
                cnt_reg <= pwdata_in[CNT_WIDTH-1:0];
            end else if (tick_w) begin
                // count up, or up then down
                if (!updown_w) begin
                    cnt_reg <= match_w ? '0 : cnt_reg + 1'b1;
                    dir_reg <= 1'b0;
                end else if (!dir_reg) begin
                    dir_reg <= match_w;
                    cnt_reg <= match_w ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
                end else begin
                    dir_reg <= ~zero_w;
                    cnt_reg <= zero_w ? cnt_reg + 1'b1 : cnt_reg - 1'b1;
                end
            end
            // edge aligned modes never report down
            if (wr_tctl0_w && !tctl0_wr_w.timebase_mode_sel[1]) begin
                dir_reg <= 1'b0;
            end
        end
    end

    // status bits: set beats a read clear
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_reg <= 2'b00;
            tbev_reg <= 1'b0;
            trev_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= (rd_stat_w ? 2'b00 : stat_reg) | {tr_ev_w, tb_ev_w};
            tbev_reg <= tb_ev_w;
            trev_reg <= tr_ev_w;
            irq_reg <= |(stat_reg & mask_reg);
        end
    end

    assign prdata_out = rdata_reg;
    assign pready_out = ready_reg;
    assign pslverr_out = 1'b0;
    assign timebase_count_out = cnt_reg;
    assign count_down_flag_out = dir_reg;
    assign center_aligned_out = tctl0_reg.timebase_mode_sel[1];
    assign tb_event_out = tbev_reg;
    assign trigger_event_out = trev_reg;
    assign duty_active_out = duty_act_reg;
    assign override_active_out = ovr_act_reg;
    assign output_pin_enable_out = octl0_reg[6:4];
    assign pair_mode_out = octl0_reg[3:0];
    assign irq_out = irq_reg;

    // direction only down in up/down modes
    dir_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        count_down_flag_out |-> center_aligned_out) else $error("down flag outside up/down mode");
    stop_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !run_reg && !wr_count_w |=> $stable(cnt_reg)) else $error("count moved while stopped");
    // single shot clears run at match
    single_stop_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick_w && match_w && tctl0_reg.timebase_mode_sel == MPTB_SINGLE && !wr_tctl1_w
        |=> !run_reg) else $error("single shot did not stop");
    duty_block_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        octl1_reg[1] |=> $stable(duty_act_reg)) else $error("duty moved while blocked");
    duty_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        duty_load_w |=> duty_active_out[VAL_W-1:0] == $past(duty_buf_reg[0])) else $error("duty not loaded");
    ovr_async_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        !octl1_reg[0] |=> override_active_out == $past(ovr_buf_reg)) else $error("override not applied");
    // up/down turns at the period match
    turn_down_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        tick_w && updown_w && match_w && !dir_reg && !wr_count_w && !wr_tctl0_w
        |=> count_down_flag_out) else $error("no turn at period");
endmodule

//--- src/mptb_pkg.sv
// package for the pwm time base control block
// assumes a single 125 MHz system clock and an apb register bus
package mptb_pkg;
    localparam int CNT_W = 12;
    localparam int VAL_W = 16;
    // byte addresses on apb
    localparam logic [7:0] ADDR_TCTL0  = 8'h00;
    localparam logic [7:0] ADDR_TCTL1  = 8'h04;
    localparam logic [7:0] ADDR_OCTL0  = 8'h08;
    localparam logic [7:0] ADDR_OCTL1  = 8'h0C;
    localparam logic [7:0] ADDR_COUNT  = 8'h10;
    localparam logic [7:0] ADDR_PERIOD = 8'h14;
    localparam logic [7:0] ADDR_TRIG   = 8'h18;
    localparam logic [7:0] ADDR_DUTY0  = 8'h1C;
    localparam logic [7:0] ADDR_STAT   = 8'h2C;
    localparam logic [7:0] ADDR_MASK   = 8'h30;
    localparam logic [7:0] ADDR_OVR    = 8'h34;
    localparam int NUM_DUTY = 4;
    // field positions
    localparam int RUN_BIT  = 7;
    localparam int DIR_BIT  = 6;
    localparam logic [7:0] TCTL1_MASK = 8'h80;
    localparam logic [7:0] OCTL0_MASK = 8'h7F;
    localparam logic [7:0] OCTL1_MASK = 8'hFB;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [2:0] PINEN_FUSE1 = 3'h7;
    localparam logic [2:0] PINEN_FUSE0 = 3'h0;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    // instruction clock divides the system clock by four
    localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
    typedef enum logic [1:0] {
        MPTB_FREE   = 2'b00,
        MPTB_SINGLE = 2'b01,
        MPTB_UPDN   = 2'b10,
        MPTB_DOUBLE = 2'b11
    } mptb_mode_t;
    typedef struct packed {
        logic [3:0] match_postscale_sel;
        logic [1:0] input_divider_sel;
        mptb_mode_t timebase_mode_sel;
    } mptb_tctl0_t;
    typedef struct packed {
        logic       period_event;
        logic       trigger_event;
    } mptb_events_t;
    // status and mask bit positions
    localparam int EV_TB   = 0;
    localparam int EV_TRIG = 1;
endpackage
